// file: core/tccu_pkg.sv
// Purpose: Shared constants and types of the timer capture/compare unit
// Assumes: 16-bit counter, 16-bit register bus with 8-bit byte address
// Notes:   Offsets are byte addresses, one word per register
package tccu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int          CNT_W    = 16;
  localparam int          ADDR_W   = 8;
  localparam int          NUM_CH   = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_OPT    = 8'h04;
  localparam logic [7:0]  OFF_IOC    = 8'h08;
  localparam logic [7:0]  OFF_CMP0   = 8'h0c;
  localparam logic [7:0]  OFF_CNT    = 8'h1c;
  localparam logic [7:0]  OFF_CAP    = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_RUN_BIT  = 0;
  localparam int          CTRL_MODE_LSB = 1;
  localparam int          CTRL_CAP_BIT  = 4;
  localparam int          CTRL_EDGE_LSB = 5;
  localparam int          OPT_OVF_BIT   = 0;
  localparam int          IOC_LVL_LSB   = 4;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [7:0]  IOC_RST    = 8'h00;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INTERVAL,
    MODE_EVENT_COUNT,
    MODE_EXT_TRIGGER,
    MODE_ONE_SHOT,
    MODE_PWM,
    MODE_FREE_RUN,
    MODE_PULSE_WIDTH
  } tccu_mode_type;

  // Edge select: 00 none, 01 rising, 10 falling, 11 both
  typedef logic [1:0] tccu_edge_type;

endpackage

// file: core/tccu_edge_if.sv
// Purpose: Carries edge select and detected edge between top and detector
// Assumes: Single clock domain
// Notes:   One instance per trigger input
`timescale 1ns/10ps
interface tccu_edge_if;
  logic [1:0] edge_sel;
  logic       edge_pulse;

  modport ctl (output edge_sel, input edge_pulse);
  modport det (input edge_sel, output edge_pulse);
endinterface

// file: core/tccu_edge_detect.sv
// Purpose: Synchronises one trigger pin and reports valid edges
// Assumes: Pin is asynchronous to clk
// Notes:   Edge pulse is one cycle, three cycles after the pin change
`timescale 1ns/10ps
module tccu_edge_detect (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  pin_in,
  tccu_edge_if.det   edge_bus
);
  import tccu_pkg::*;

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic pulse_reg;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= (edge_bus.edge_sel[0] & sync2_reg & ~prev_reg) |
                   (edge_bus.edge_sel[1] & ~sync2_reg & prev_reg);
    end
  end

  assign edge_bus.edge_pulse = pulse_reg;

endmodule // tccu_edge_detect

// file: core/tccu_top.sv
// Purpose: 16-bit timer with four compare channels and channel-1 capture
// Assumes: One 50 MHz clock, asynchronous active-high reset
// Notes:   Count rate is clk divided by PRESCALE; event-count mode counts capture_trigger_in0 edges
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module tccu_top #(
  parameter int PRESCALE = 1
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [tccu_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [tccu_pkg::CNT_W-1:0]  bus_wdata,
  input  wire logic                       bus_wr,
  input  wire logic                       bus_rd,
  output logic      [tccu_pkg::CNT_W-1:0]  bus_rdata,
  input  wire logic                       capture_trigger_in0,
  input  wire logic                       capture_trigger_in1,
  output logic      [tccu_pkg::NUM_CH-1:0] timer_out,
  output logic      [tccu_pkg::NUM_CH-1:0] compare_match_irq,
  output logic                            overflow_flag
);
  import tccu_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic is_batch(input tccu_mode_type m);
    case (m)
      MODE_EXT_TRIGGER: is_batch = 1'b1;
      MODE_PWM:         is_batch = 1'b1;
      default:          is_batch = 1'b0;
    endcase
  endfunction

  function automatic logic [NUM_CH-1:0] out_drive(input tccu_mode_type m, input logic cap);
    case (m)
      MODE_EVENT_COUNT: out_drive = 4'h0;
      MODE_PULSE_WIDTH: out_drive = 4'h0;
      MODE_FREE_RUN:    out_drive = cap ? 4'hd : 4'hf;
      default:          out_drive = 4'hf;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]          ctrl_reg;
  logic [7:0]           ioc_reg;
  logic [CNT_W-1:0]     cmp_reg [NUM_CH];
  logic [CNT_W-1:0]     shadow_reg [NUM_CH];
  logic [CNT_W-1:0]     count_reg;
  logic [CNT_W-1:0]     capture_reg;
  logic [CNT_W-1:0]     rdata_reg;
  logic                 ovf_reg;
  logic                 arm_reg;
  logic                 run_prev_reg;
  logic [NUM_CH-1:0]    tog_reg;
  logic [NUM_CH-1:0]    pin_reg;
  logic [NUM_CH-1:0]    irq_reg;
  logic [15:0]          div_reg;
  logic                 tick;
  logic                 step;
  logic                 run;
  logic                 cap_sel;
  logic                 batch;
  tccu_mode_type        mode;
  logic [NUM_CH-1:0]    match;
  logic [NUM_CH-1:0]    drive;
  logic                 cap_edge;
  logic                 ev_edge;
  logic                 cap_event;
  logic                 transfer;
  logic                 wr_cmp1;

  tccu_edge_if ev_if ();
  tccu_edge_if cap_if ();

  assign run     = ctrl_reg[CTRL_RUN_BIT];
  assign mode    = tccu_mode_type'(ctrl_reg[CTRL_MODE_LSB +: 3]);
  assign cap_sel = ctrl_reg[CTRL_CAP_BIT];
  assign batch   = is_batch(mode);
  assign drive   = out_drive(mode, cap_sel);

  // ----------------------------------------------------------------
  // Trigger inputs
  // ----------------------------------------------------------------
  assign ev_if.edge_sel  = ctrl_reg[CTRL_EDGE_LSB +: 2];
  assign cap_if.edge_sel = ctrl_reg[CTRL_EDGE_LSB +: 2];
  assign ev_edge         = ev_if.edge_pulse;
  assign cap_edge        = cap_if.edge_pulse;

  tccu_edge_detect u_ev_det (
    .clk      (clk),
    .rst      (rst),
    .pin_in   (capture_trigger_in0),
    .edge_bus (ev_if)
  );

  tccu_edge_detect u_cap_det (
    .clk      (clk),
    .rst      (rst),
    .pin_in   (capture_trigger_in1),
    .edge_bus (cap_if)
  );

  // Capture happens in free-run with capture selected, or in pulse-width mode
  assign cap_event = run & cap_edge &
                     ((mode == MODE_FREE_RUN & cap_sel) | (mode == MODE_PULSE_WIDTH));

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 16'h0000;
    end else if (!run || div_reg == 16'(PRESCALE - 1)) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  assign tick = run & (div_reg == 16'(PRESCALE - 1));
  assign step = (mode == MODE_EVENT_COUNT) ? (run & ev_edge) : tick;

  // ----------------------------------------------------------------
  // Compare match
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_match
      if (gi == 1) begin : g_ch1
        assign match[gi] = step & (count_reg == shadow_reg[gi]) &
                           (mode != MODE_PULSE_WIDTH) &
                           !(mode == MODE_FREE_RUN && cap_sel);
      end else begin : g_chn
        assign match[gi] = step & (count_reg == shadow_reg[gi]) &
                           (mode != MODE_PULSE_WIDTH);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 4'h0;
    end else begin
      irq_reg <= match;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= CNT_ZERO;
    end else if (!run) begin
      count_reg <= CNT_ZERO;
    end else if (cap_event && mode == MODE_PULSE_WIDTH) begin
      count_reg <= CNT_ZERO;
    end else if (step) begin
      if (match[0] && mode != MODE_FREE_RUN) begin
        count_reg <= CNT_ZERO;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_reg <= 1'b0;
    end else if (step && count_reg == CNT_MAX &&
                 !(cap_event && mode == MODE_PULSE_WIDTH) &&
                 (mode == MODE_FREE_RUN || mode == MODE_PULSE_WIDTH)) begin
      ovf_reg <= 1'b1;
    end else if (bus_wr && hit(bus_addr, OFF_OPT) && !bus_wdata[OPT_OVF_BIT]) begin
      ovf_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Capture register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_reg <= CNT_ZERO;
    end else if (cap_event) begin
      capture_reg <= count_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      ioc_reg  <= IOC_RST;
    end else if (bus_wr) begin
      if (hit(bus_addr, OFF_CTRL)) begin
        ctrl_reg <= bus_wdata;
      end
      if (hit(bus_addr, OFF_IOC)) begin
        ioc_reg <= bus_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare registers and shadows
  // ----------------------------------------------------------------
  assign wr_cmp1  = bus_wr & hit(bus_addr, OFF_CMP0 + 8'h04);
  assign transfer = batch & match[0] & arm_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_reg <= 1'b0;
    end else if (wr_cmp1 && batch) begin
      arm_reg <= 1'b1;
    end else if (transfer || !run) begin
      arm_reg <= 1'b0;
    end
  end

  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_cmp
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cmp_reg[gi] <= CMP_RST;
        end else if (bus_wr && hit(bus_addr, OFF_CMP0 + 8'(4 * gi))) begin
          cmp_reg[gi] <= bus_wdata;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          shadow_reg[gi] <= CMP_RST;
        end else if (!run || (batch && transfer)) begin
          shadow_reg[gi] <= cmp_reg[gi];
        end else if (!batch && bus_wr && hit(bus_addr, OFF_CMP0 + 8'(4 * gi))) begin
          shadow_reg[gi] <= bus_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output waveforms
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run;
    end
  end

  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_out
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          tog_reg[gi] <= 1'b0;
        end else if (!run) begin
          tog_reg[gi] <= 1'b0;
        end else if (!run_prev_reg) begin
          tog_reg[gi] <= 1'b1;
        end else begin
          case (mode)
            MODE_INTERVAL, MODE_FREE_RUN: begin
              if (match[gi]) begin
                tog_reg[gi] <= ~tog_reg[gi];
              end
            end
            MODE_EXT_TRIGGER, MODE_ONE_SHOT, MODE_PWM: begin
              if (gi == 0) begin
                if (match[0]) begin
                  tog_reg[gi] <= ~tog_reg[gi];
                end
              end else if (match[gi]) begin
                tog_reg[gi] <= 1'b0;
              end else if (match[0]) begin
                tog_reg[gi] <= 1'b1;
              end
            end
            default: begin
              tog_reg[gi] <= tog_reg[gi];
            end
          endcase
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_reg[gi] <= 1'b0;
        end else begin
          pin_reg[gi] <= ioc_reg[IOC_LVL_LSB + gi] ^
                         (ioc_reg[gi] & run & drive[gi] & tog_reg[gi]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (bus_rd) begin
      if (hit(bus_addr, OFF_CTRL)) begin
        rdata_reg <= ctrl_reg;
      end else if (hit(bus_addr, OFF_OPT)) begin
        rdata_reg <= {15'h0000, ovf_reg};
      end else if (hit(bus_addr, OFF_IOC)) begin
        rdata_reg <= {8'h00, ioc_reg};
      end else if (hit(bus_addr, OFF_CMP0)) begin
        rdata_reg <= cmp_reg[0];
      end else if (hit(bus_addr, OFF_CMP0 + 8'h04)) begin
        rdata_reg <= (cap_sel || mode == MODE_PULSE_WIDTH) ? capture_reg : cmp_reg[1];
      end else if (hit(bus_addr, OFF_CMP0 + 8'h08)) begin
        rdata_reg <= cmp_reg[2];
      end else if (hit(bus_addr, OFF_CMP0 + 8'h0c)) begin
        rdata_reg <= cmp_reg[3];
      end else if (hit(bus_addr, OFF_CNT)) begin
        rdata_reg <= count_reg;
      end else if (hit(bus_addr, OFF_CAP)) begin
        rdata_reg <= capture_reg;
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign bus_rdata         = rdata_reg;
  assign timer_out         = pin_reg;
  assign compare_match_irq = irq_reg;
  assign overflow_flag     = ovf_reg;

endmodule // tccu_top

// file: tb/tccu_monitor.sv
// Purpose: Port-level checks of the timer capture/compare unit
// Assumes: Register map and pin equation of the timer top module
// Notes:   Tracks control and io control words from bus writes
`timescale 1ns/10ps
module tccu_monitor #(
  parameter int PRESCALE = 1
) (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic [tccu_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [tccu_pkg::CNT_W-1:0]  bus_wdata,
  input wire logic                        bus_wr,
  input wire logic                        bus_rd,
  input wire logic [tccu_pkg::CNT_W-1:0]  bus_rdata,
  input wire logic                        capture_trigger_in0,
  input wire logic                        capture_trigger_in1,
  input wire logic [tccu_pkg::NUM_CH-1:0] timer_out,
  input wire logic [tccu_pkg::NUM_CH-1:0] compare_match_irq,
  input wire logic                        overflow_flag
);
  import tccu_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of control words
  // ----------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [7:0] ioc_q;
  logic [2:0] settle_q;
  logic [2:0] mode;
  logic       run;
  logic       quiet;
  assign mode  = ctrl_q[3:1];
  assign run   = ctrl_q[CTRL_RUN_BIT];
  assign quiet = settle_q[2];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= CTRL_RST[3:0];
      ioc_q    <= IOC_RST;
      settle_q <= 3'h0;
    end else if (bus_wr && bus_addr == OFF_CTRL) begin
      ctrl_q   <= bus_wdata[3:0];
      settle_q <= 3'h0;
    end else if (bus_wr && bus_addr == OFF_IOC) begin
      ioc_q    <= bus_wdata[7:0];
      settle_q <= 3'h0;
    end else if (!quiet) begin
      settle_q <= settle_q + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reset_outputs_a: assert property ($fell(rst) |-> timer_out == 4'h0
    && compare_match_irq == 4'h0 && !overflow_flag) else $error("outputs not idle after reset");
  rdata_hold_a: assert property (!$past(bus_rd) |-> $stable(bus_rdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (bus_rd && bus_addr > OFF_CAP |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  ioc_readback_a: assert property (bus_rd && bus_addr == OFF_IOC
    |=> bus_rdata == {8'h00, $past(ioc_q)}) else $error("io control read back wrong");
  ovf_sticky_a: assert property (overflow_flag
    && !(bus_wr && bus_addr == OFF_OPT && !bus_wdata[OPT_OVF_BIT]) |=> overflow_flag)
    else $error("overflow flag dropped");
  ovf_clear_a: assert property (overflow_flag && bus_wr && bus_addr == OFF_OPT
    && !bus_wdata[OPT_OVF_BIT] |=> !overflow_flag) else $error("overflow flag not cleared");
  idle_level_a: assert property (quiet |->
    ((timer_out ^ ioc_q[7:4]) & ~(ioc_q[3:0] & {4{run}})) == 4'h0)
    else $error("idle pin not at level select");
  silent_modes_a: assert property (quiet && (mode == MODE_EVENT_COUNT
    || mode == MODE_PULSE_WIDTH) |-> timer_out == ioc_q[7:4]) else $error("pin driven in mode");
  pw_no_irq_a: assert property (quiet && mode == MODE_PULSE_WIDTH
    |-> compare_match_irq == 4'h0) else $error("match in pulse-width mode");
  match_toggle_a: assert property (quiet && run && mode == MODE_INTERVAL && ioc_q[0]
    && compare_match_irq[0] |=> timer_out[0] != $past(timer_out[0]))
    else $error("pin 0 did not toggle on match");
  toggle_cause_a: assert property (quiet && run && mode == MODE_INTERVAL
    && $changed(timer_out[0]) |-> $past(compare_match_irq[0]))
    else $error("pin 0 toggled without match");
  cover property (compare_match_irq[0] && timer_out[0]);
  cover property ($rose(overflow_flag));
  cover property (quiet && run && mode == MODE_PULSE_WIDTH);
endmodule // tccu_monitor

bind tccu_top tccu_monitor #(.PRESCALE(PRESCALE)) tccu_monitor_i (
  .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .capture_trigger_in0(capture_trigger_in0),
  .capture_trigger_in1(capture_trigger_in1), .timer_out(timer_out),
  .compare_match_irq(compare_match_irq), .overflow_flag(overflow_flag));

// file: tb/tccu_trig_model.sv
// Purpose: Drives the two capture trigger pins
// Assumes: Both edges selected as valid
// Notes:   Each request bit toggles its pin once
`timescale 1ns/10ps
module tccu_trig_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] edge_req,
  output logic      [1:0] trig_pin
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_pin <= 2'b00;
    end else begin
      trig_pin <= trig_pin ^ edge_req;
    end
  end
endmodule // tccu_trig_model

// file: tb/tccu_tb_top.sv
// Purpose: Register-level tests of the timer capture/compare unit
// Assumes: PRESCALE of 1, register map of the timer top module
// Notes:   Overflow test runs one full counter wrap
`timescale 1ns/10ps
module tccu_tb_top;
  import tccu_pkg::*;
  logic        clk;
  logic        rst;
  logic [7:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_rdata;
  logic [1:0]  edge_req;
  logic [1:0]  trig_pin;
  logic [3:0]  timer_out;
  logic [3:0]  irq;
  logic        ovf;
  logic [15:0] rv;
  logic [15:0] cap;
  logic        p;
  int          bad_count;
  int          n_compared;
  int          cyc;
  int          t;
  tccu_top #(.PRESCALE(1)) tccu_top_i (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .capture_trigger_in0(trig_pin[0]), .capture_trigger_in1(trig_pin[1]),
    .timer_out(timer_out), .compare_match_irq(irq), .overflow_flag(ovf));
  tccu_trig_model tccu_trig_model_i (.clk(clk), .rst(rst), .edge_req(edge_req),
    .trig_pin(trig_pin));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    rv = bus_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string s);
    rd(a);
    chk(s, e, rv);
  endtask
  task automatic wait_irq(input int ch, input int lim);
    t = 0;
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (irq[ch] !== 1'b1 && t < lim);
  endtask
  task automatic pulse_edge();
    @(posedge clk);
    edge_req <= 2'b10;
    @(posedge clk);
    edge_req <= 2'b00;
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and tests
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    edge_req = 2'b00;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h24, 16'h0000, "unmapped");
    chk("pins after reset", 16'h0000, {12'h000, timer_out});
    wr(OFF_CMP0, 16'h0004);
    wr(OFF_IOC, 16'h000f);
    wr(OFF_CTRL, 16'h0001);
    wait_irq(0, 50);
    p = timer_out[0];
    wait_irq(0, 50);
    chk("interval period", 16'h0005, 16'(t));
    chk("pin0 toggle", {15'h0000, ~p}, {15'h0000, timer_out[0]});
    wr(OFF_CMP0 + 8'h04, 16'h0002);
    wait_irq(1, 10);
    chk("irq1 running write", 16'h0001, {15'h0000, irq[1]});
    rdchk(OFF_CMP0 + 8'h04, 16'h0002, "cmp1");
    wr(OFF_CTRL, 16'h0000);
    wr(OFF_IOC, 16'h00f0);
    wr(OFF_CTRL, 16'h0001);
    repeat (6) @(posedge clk);
    #1;
    chk("pins level one", 16'h000f, {12'h000, timer_out});
    wr(OFF_IOC, 16'h000f);
    for (int m = 0; m < 7; m++) begin
      wr(OFF_CTRL, 16'h0000);
      wr(OFF_CTRL, 16'(m * 2 + 1));
      wait_irq(0, 30);
      chk("irq0 by mode", (m == 1 || m == 6) ? 16'h0000 : 16'h0001, 16'(irq[0]));
    end
    wr(OFF_CTRL, 16'h0000);
    wr(OFF_CMP0, 16'h0009);
    wr(OFF_CTRL, 16'h0009);
    wait_irq(0, 50);
    wait_irq(0, 50);
    chk("pwm period", 16'h000a, 16'(t));
    wr(OFF_CMP0, 16'h0013);
    wait_irq(0, 50);
    wait_irq(0, 50);
    chk("unarmed period", 16'h000a, 16'(t));
    wr(OFF_CMP0 + 8'h04, 16'h0002);
    wait_irq(0, 50);
    wait_irq(0, 50);
    chk("batch period", 16'h0014, 16'(t));
    wr(OFF_CTRL, 16'h0000);
    wr(OFF_CTRL, 16'h007b);
    repeat (40) @(posedge clk);
    pulse_edge();
    repeat (10) @(posedge clk);
    rd(OFF_CAP);
    cap = rv;
    chk("free-run capture", 16'h0001, 16'(cap >= 16'h0026 && cap <= 16'h0032));
    rdchk(OFF_CMP0 + 8'h04, cap, "capture via ch1");
    wr(OFF_CTRL, 16'h0000);
    wr(OFF_CTRL, 16'h006d);
    repeat (60) @(posedge clk);
    pulse_edge();
    repeat (2) @(posedge clk);
    rdchk(OFF_CAP, cap, "capture collide");
    rd(OFF_CNT);
    chk("count cleared", 16'h0001, 16'(rv < 16'h0014));
    rd(OFF_CAP);
    chk("pulse width", 16'h0001, 16'(rv >= 16'h0038 && rv <= 16'h0046));
    wr(OFF_CTRL, 16'h0000);
    wr(OFF_CTRL, 16'h000b);
    wait (ovf === 1'b1);
    chk("overflow set", 16'h0001, {15'h0000, ovf});
    rd(OFF_CNT);
    chk("count after wrap", 16'h0001, rv);
    rdchk(OFF_OPT, 16'h0001, "option read");
    wr(OFF_OPT, 16'h0001);
    rdchk(OFF_OPT, 16'h0001, "option kept");
    wr(OFF_OPT, 16'h0000);
    rdchk(OFF_OPT, 16'h0000, "option cleared");
    results();
  end
endmodule // tccu_tb_top
